// file: hw/css_pkg.sv
package css_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] CSS_IDX_THR = 8'h0f;
    localparam logic [7:0] CSS_IDX_IFSEL = 8'h11;
    localparam logic [7:0] CSS_IDX_MUX = 8'h12;
    localparam logic [7:0] CSS_IDX_POL = 8'h20;
    localparam logic [7:0] CSS_IDX_STAT = 8'h21;

    localparam int CSS_BIT_IFSEL = 3;
    localparam int CSS_BIT_HOLDSEL = 1;
    localparam int CSS_BIT_SEPSEL = 2;
    localparam int CSS_BIT_GRNSEL = 4;
    localparam int CSS_BIT_POL = 0;
    localparam int CSS_BIT_DET = 8;

    localparam logic [7:0] CSS_THR_RST = 8'h20;
    localparam logic [7:0] CSS_IFSEL_RST = 8'h00;
    localparam logic [7:0] CSS_MUX_RST = 8'h00;
    localparam logic [7:0] CSS_POL_RST = 8'h00;

    localparam int CSS_CLK_HZ = 100_000_000;
    localparam int CSS_TICK_HZ = 5_000_000;
    localparam int CSS_TICK_DIV = CSS_CLK_HZ / CSS_TICK_HZ;

    localparam logic [1:0] CSS_RESP_OKAY = 2'b00;
    localparam logic [1:0] CSS_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic sync_on_green;
        logic pll_hold_gate;
    } css_ana_t;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic de;
    } css_dig_t;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic hold;
    } css_sync_t;

    typedef enum logic [1:0] {
        CSS_SEP_SEEK = 2'b01,
        CSS_SEP_HELD = 2'b10
    } css_sep_st_t;

endpackage

// file: hw/css_sep.sv
module css_sep
    import css_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic csync,
    input wire logic [CNT_W-1:0] thr,
    output logic det,
    output logic [CNT_W-1:0] cnt
);

    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    css_sep_st_t state_r;
    logic [CNT_W-1:0] cnt_r;

    // A threshold of all ones can never be exceeded: detection is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= CSS_SEP_SEEK;
            cnt_r <= '0;
        end else begin
            unique case (state_r)
                CSS_SEP_SEEK: begin
                    if (cnt_r > thr) begin
                        state_r <= CSS_SEP_HELD;
                        cnt_r <= '0;
                    end else if (tick) begin
                        if (csync) begin
                            if (cnt_r != CNT_MAX) begin
                                cnt_r <= cnt_r + CNT_ONE;
                            end
                        end else if (cnt_r != '0) begin
                            cnt_r <= cnt_r - CNT_ONE;
                        end
                    end
                end
                CSS_SEP_HELD: begin
                    if (cnt_r >= thr) begin
                        state_r <= CSS_SEP_SEEK;
                        cnt_r <= '0;
                    end else if (tick) begin
                        // Serrations restart the absence count
                        if (csync) begin
                            cnt_r <= '0;
                        end else if (cnt_r != CNT_MAX) begin
                            cnt_r <= cnt_r + CNT_ONE;
                        end
                    end
                end
                default: begin
                    state_r <= CSS_SEP_SEEK;
                    cnt_r <= '0;
                end
            endcase
        end
    end

    assign det = (state_r == CSS_SEP_HELD);
    assign cnt = cnt_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_seek_count_up: assert property (
        state_r == CSS_SEP_SEEK && !(cnt_r > thr) && tick && csync
        && cnt_r != CNT_MAX |=> cnt_r == $past(cnt_r) + CNT_ONE)
        else $error("count did not rise on active sync");
    a_seek_count_down: assert property (
        state_r == CSS_SEP_SEEK && !(cnt_r > thr) && tick && !csync
        && cnt_r != '0 |=> cnt_r == $past(cnt_r) - CNT_ONE)
        else $error("count did not fall on idle sync");
    a_count_limits: assert property (
        state_r == CSS_SEP_SEEK && !(cnt_r > thr) && cnt_r == '0
        && !csync |=> cnt_r == '0)
        else $error("count went below zero");
    a_detect_enter: assert property (
        state_r == CSS_SEP_SEEK && cnt_r > thr
        |=> det && cnt_r == '0)
        else $error("vsync not declared above threshold");
    a_detect_leave: assert property (
        det && cnt_r >= thr |=> !det && cnt_r == '0 ##1 !det)
        else $error("vsync not ended at threshold");
    a_held_restart: assert property (
        det && cnt_r < thr && tick && csync |=> cnt_r == '0)
        else $error("absence count not cleared by sync");
    a_det_stable: assert property (
        !det ##1 det |-> $past(cnt_r) > $past(thr))
        else $error("vsync asserted without cause");

    c_detect: cover property (!det ##1 det);
    c_release: cover property (det ##1 !det);
    c_saturate: cover property (cnt_r == CNT_MAX);

endmodule

// file: hw/css_top.sv
// Implementation choices: the AXI4-Lite register port and the register addresses.
module css_top
    import css_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire css_ana_t ana_in,
    input wire css_dig_t dig_in,
    output css_sync_t sync_out
);

    localparam int DIV_W = $clog2(CSS_TICK_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CSS_TICK_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

    if (CNT_W < 2 || CNT_W > 8) begin : g_cnt_chk
        $error("CNT_W must lie between 2 and 8");
    end
    if (ADDR_W < 8) begin : g_addr_chk
        $error("ADDR_W too small for the register map");
    end

    function automatic logic css_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0] idx
    );
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = ADDR_W'({idx, 2'b00});
        return addr == byte_addr;
    endfunction

    // Pin synchronisers
    css_ana_t ana_s1_r;
    css_ana_t ana_s2_r;
    css_dig_t dig_s1_r;
    css_dig_t dig_s2_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ana_s1_r <= '0;
            ana_s2_r <= '0;
            dig_s1_r <= '0;
            dig_s2_r <= '0;
        end else begin
            ana_s1_r <= ana_in;
            ana_s2_r <= ana_s1_r;
            dig_s1_r <= dig_in;
            dig_s2_r <= dig_s1_r;
        end
    end

    // 5 MHz enable
    logic [DIV_W-1:0] div_r;
    logic tick_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else if (div_r == DIV_LAST) begin
            div_r <= '0;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + DIV_ONE;
            tick_r <= 1'b0;
        end
    end

    // Control registers
    logic [CNT_W-1:0] thr_r;
    logic ifsel_r;
    logic holdsel_r;
    logic sepsel_r;
    logic sogsel_r;
    logic pol_r;

    // Write channel
    logic aw_have_r;
    logic w_have_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic wen_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic commit;
    logic wr_thr;
    logic wr_ifsel;
    logic wr_mux;
    logic wr_pol;
    logic wr_ok;

    assign commit = aw_have_r && w_have_r && !bvalid_r;
    assign wr_thr = css_hit(awaddr_r, CSS_IDX_THR);
    assign wr_ifsel = css_hit(awaddr_r, CSS_IDX_IFSEL);
    assign wr_mux = css_hit(awaddr_r, CSS_IDX_MUX);
    assign wr_pol = css_hit(awaddr_r, CSS_IDX_POL);
    assign wr_ok = wr_thr || wr_ifsel || wr_mux || wr_pol
        || css_hit(awaddr_r, CSS_IDX_STAT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            awaddr_r <= '0;
            awready_r <= 1'b0;
        end else if (s_axi_awvalid && awready_r) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            awready_r <= 1'b0;
        end else if (commit) begin
            aw_have_r <= 1'b0;
        end else if (!aw_have_r && !bvalid_r) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            wbyte_r <= '0;
            wen_r <= 1'b0;
            wready_r <= 1'b0;
        end else if (s_axi_wvalid && wready_r) begin
            w_have_r <= 1'b1;
            wbyte_r <= s_axi_wdata[7:0];
            wen_r <= s_axi_wstrb[0];
            wready_r <= 1'b0;
        end else if (commit) begin
            w_have_r <= 1'b0;
        end else if (!w_have_r && !bvalid_r) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= CSS_RESP_OKAY;
        end else if (commit) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? CSS_RESP_OKAY : CSS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Only byte lane 0 carries register data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thr_r <= CSS_THR_RST[CNT_W-1:0];
            ifsel_r <= CSS_IFSEL_RST[CSS_BIT_IFSEL];
            holdsel_r <= CSS_MUX_RST[CSS_BIT_HOLDSEL];
            sepsel_r <= CSS_MUX_RST[CSS_BIT_SEPSEL];
            sogsel_r <= CSS_MUX_RST[CSS_BIT_GRNSEL];
            pol_r <= CSS_POL_RST[CSS_BIT_POL];
        end else if (commit && wen_r) begin
            if (wr_thr) begin
                thr_r <= wbyte_r[CNT_W-1:0];
            end
            if (wr_ifsel) begin
                ifsel_r <= wbyte_r[CSS_BIT_IFSEL];
            end
            if (wr_mux) begin
                holdsel_r <= wbyte_r[CSS_BIT_HOLDSEL];
                sepsel_r <= wbyte_r[CSS_BIT_SEPSEL];
                sogsel_r <= wbyte_r[CSS_BIT_GRNSEL];
            end
            if (wr_pol) begin
                pol_r <= wbyte_r[CSS_BIT_POL];
            end
        end
    end

    // Sync path
    logic sep_det;
    logic [CNT_W-1:0] sep_cnt;
    logic mux_hs;
    logic csync_norm;
    css_sync_t ana_sync;
    css_sync_t dig_sync;
    css_sync_t out_r;

    assign mux_hs = sogsel_r ? ana_s2_r.sync_on_green
        : ana_s2_r.hsync;
    // Active-low composite is inverted so the counter sees high pulses
    assign csync_norm = pol_r ? mux_hs : !mux_hs;

    css_sep #(
        .CNT_W(CNT_W)
    ) u_sep (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick_r),
        .csync(csync_norm),
        .thr(thr_r),
        .det(sep_det),
        .cnt(sep_cnt)
    );

    always_comb begin
        ana_sync.hsync = mux_hs;
        ana_sync.hold = holdsel_r ? ana_s2_r.vsync
            : ana_s2_r.pll_hold_gate;
        ana_sync.vsync = sepsel_r ? sep_det : ana_s2_r.vsync;
        dig_sync.hsync = dig_s2_r.hsync;
        dig_sync.vsync = dig_s2_r.vsync;
        dig_sync.hold = dig_s2_r.de;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_r <= '0;
        end else begin
            out_r <= ifsel_r ? ana_sync : dig_sync;
        end
    end

    // Read channel
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] rd_data;
    logic rd_ok;

    always_comb begin
        rd_data = '0;
        rd_ok = 1'b1;
        if (css_hit(s_axi_araddr, CSS_IDX_THR)) begin
            rd_data[CNT_W-1:0] = thr_r;
        end else if (css_hit(s_axi_araddr, CSS_IDX_IFSEL)) begin
            rd_data[CSS_BIT_IFSEL] = ifsel_r;
        end else if (css_hit(s_axi_araddr, CSS_IDX_MUX)) begin
            rd_data[CSS_BIT_HOLDSEL] = holdsel_r;
            rd_data[CSS_BIT_SEPSEL] = sepsel_r;
            rd_data[CSS_BIT_GRNSEL] = sogsel_r;
        end else if (css_hit(s_axi_araddr, CSS_IDX_POL)) begin
            rd_data[CSS_BIT_POL] = pol_r;
        end else if (css_hit(s_axi_araddr, CSS_IDX_STAT)) begin
            rd_data[CNT_W-1:0] = sep_cnt;
            rd_data[CSS_BIT_DET] = sep_det;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= CSS_RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_data;
            rresp_r <= rd_ok ? CSS_RESP_OKAY : CSS_RESP_SLVERR;
        end else if (rvalid_r) begin
            if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end else begin
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign sync_out = out_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_tick_period: assert property (
        tick_r |-> ##20 tick_r)
        else $error("tick spacing is not 20 cycles");
    a_tick_single: assert property (
        tick_r |=> !tick_r [*8])
        else $error("tick lasted more than one cycle");
    a_hsync_route: assert property (
        ifsel_r && $stable(ifsel_r) |=>
        sync_out.hsync == $past(sogsel_r ? ana_s2_r.sync_on_green
            : ana_s2_r.hsync))
        else $error("analog hsync mux picked wrong source");
    a_hold_route: assert property (
        ifsel_r |=> sync_out.hold == $past(holdsel_r
            ? ana_s2_r.vsync : ana_s2_r.pll_hold_gate))
        else $error("hold mux picked wrong source");
    a_vsync_route: assert property (
        ifsel_r && sepsel_r |=> sync_out.vsync == $past(sep_det))
        else $error("vsync mux did not pass the separator");
    a_digital_route: assert property (
        !ifsel_r |=> sync_out.hsync == $past(dig_s2_r.hsync)
        && sync_out.hold == $past(dig_s2_r.de))
        else $error("digital signals not passed");
    a_polarity_norm: assert property (
        !pol_r |-> csync_norm != mux_hs)
        else $error("active-low composite not inverted");
    a_write_resp: assert property (
        commit |=> bvalid_r ##0 (bresp_r == CSS_RESP_OKAY) == $past(wr_ok))
        else $error("write response does not match decode");
    a_thr_update: assert property (
        commit && wen_r && wr_thr |=> thr_r == $past(wbyte_r[CNT_W-1:0]))
        else $error("threshold write lost");
    a_thr_hold: assert property (
        !(commit && wen_r && wr_thr) |=> thr_r == $past(thr_r))
        else $error("threshold changed without a write");
    a_vsync_direct: assert property (
        ifsel_r && !sepsel_r |=> sync_out.vsync == $past(ana_s2_r.vsync))
        else $error("vsync mux did not pass the vsync pin");
    a_digital_vsync: assert property (
        !ifsel_r |=> sync_out.vsync == $past(dig_s2_r.vsync))
        else $error("digital vsync not passed");
    a_stat_detect: assert property (
        s_axi_arvalid && arready_r && css_hit(s_axi_araddr, CSS_IDX_STAT)
        |=> rdata_r[CSS_BIT_DET] == $past(sep_det))
        else $error("status read lost the vsync flag");
    // Refused reads must not leak stale data
    a_read_unmapped: assert property (
        s_axi_arvalid && arready_r && !rd_ok
        |=> rdata_r == '0 && rresp_r == CSS_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_one_write: assert property (
        bvalid_r |-> !awready_r && !wready_r)
        else $error("new write offered before the response");

    c_write: cover property (commit && wr_mux);
    c_read_stat: cover property (s_axi_arvalid && arready_r
        && css_hit(s_axi_araddr, CSS_IDX_STAT));

endmodule

// file: verif/css_src_model.sv
module css_src_model
    import css_pkg::*;
(
    input wire logic aclk,
    input wire css_ana_t ana_set,
    input wire css_dig_t dig_set,
    output css_ana_t ana_in,
    output css_dig_t dig_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Source pins are plain levels; the bench picks them per scenario
    always @(posedge aclk) begin
        ana_in <= ana_set;
        dig_in <= dig_set;
    end
endmodule

// file: verif/tb_css_top.sv
module tb_css_top
    import css_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    css_sync_t sync_out;
    css_ana_t ana_set = '0;
    css_ana_t ana_in;
    css_dig_t dig_set = '0;
    css_dig_t dig_in;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 32'h119276a7;
    logic cur_hi, cur_grn;

    css_top css_top_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ana_in(ana_in), .dig_in(dig_in), .sync_out(sync_out));

    css_src_model css_src_model_i (.aclk(aclk), .ana_set(ana_set),
        .dig_set(dig_set), .ana_in(ana_in), .dig_in(dig_in));

    always #5 aclk = ~aclk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Generous ceiling: the scenarios need about 15k cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                      input logic [3:0] st, input logic [1:0] er);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        awaddr <= {idx[5:0], 2'b00};
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && awready) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= {idx[5:0], 2'b00};
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp,
                         input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk(d, exp, "rdata");
        chk({30'h0, r}, {30'h0, er}, "rresp");
    endtask

    function automatic css_sync_t exp_sync(logic ifs, logic [7:0] mx,
                                           css_ana_t a, css_dig_t d);
        css_sync_t s;
        if (!ifs) begin
            s = '{d.hsync, d.vsync, d.de};
        end else begin
            s.hsync = mx[4] ? a.sync_on_green : a.hsync;
            s.vsync = mx[2] ? 1'b0 : a.vsync;
            s.hold = mx[1] ? a.vsync : a.pll_hold_gate;
        end
        return s;
    endfunction

    // Composite on the selected line, at the active level when act is 1
    task automatic drive(input logic act, input int n);
        if (cur_grn) begin
            ana_set.sync_on_green <= act ~^ cur_hi;
        end else begin
            ana_set.hsync <= act ~^ cur_hi;
        end
        repeat (n) @(posedge aclk);
    endtask

    task automatic sep_case(input logic hi, input logic grn);
        logic [31:0] d;
        logic [1:0] r;
        cur_hi = hi;
        cur_grn = grn;
        ana_set <= '0;
        wr(CSS_IDX_POL, {31'h0, hi}, 4'hf, CSS_RESP_OKAY);
        wr(CSS_IDX_MUX, grn ? 32'h14 : 32'h04, 4'hf, CSS_RESP_OKAY);
        wr(CSS_IDX_IFSEL, 32'h08, 4'hf, CSS_RESP_OKAY);
        wr(CSS_IDX_THR, 32'h05, 4'hf, CSS_RESP_OKAY);
        drive(1'b0, 300);
        rdchk(CSS_IDX_STAT, 32'h0, CSS_RESP_OKAY);
        drive(1'b1, 60);
        drive(1'b0, 0);
        rd(CSS_IDX_STAT, d, r);
        chk({31'h0, d[8]}, 32'h0, "line pulse detected");
        drive(1'b0, 200);
        rdchk(CSS_IDX_STAT, 32'h0, CSS_RESP_OKAY);
        drive(1'b1, 200);
        rdchk(CSS_IDX_STAT, 32'h100, CSS_RESP_OKAY);
        chk({31'h0, sync_out.vsync}, 32'h1, "vsync out");
        drive(1'b0, 50);
        drive(1'b1, 30);
        drive(1'b0, 60);
        rd(CSS_IDX_STAT, d, r);
        chk({31'h0, d[8]}, 32'h1, "serration ends vsync");
        drive(1'b0, 200);
        rdchk(CSS_IDX_STAT, 32'h0, CSS_RESP_OKAY);
        chk({31'h0, sync_out.vsync}, 32'h0, "vsync out end");
        $display("test separator pol %0d green %0d done", hi, grn);
    endtask

    initial begin : main
        logic [31:0] d, ifs, mx, ra, rg;
        logic [1:0] r;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdchk(CSS_IDX_THR, 32'h20, CSS_RESP_OKAY);
        rdchk(CSS_IDX_IFSEL, 32'h0, CSS_RESP_OKAY);
        rdchk(CSS_IDX_MUX, 32'h0, CSS_RESP_OKAY);
        rdchk(CSS_IDX_POL, 32'h0, CSS_RESP_OKAY);
        rdchk(8'h01, 32'h0, CSS_RESP_SLVERR);
        wr(8'h01, 32'h55, 4'hf, CSS_RESP_SLVERR);
        wr(CSS_IDX_THR, 32'h77, 4'he, CSS_RESP_OKAY);
        rdchk(CSS_IDX_THR, 32'h20, CSS_RESP_OKAY);
        wr(CSS_IDX_STAT, 32'hff, 4'hf, CSS_RESP_OKAY);
        wr(CSS_IDX_THR, 32'hffffffff, 4'hf, CSS_RESP_OKAY);
        rdchk(CSS_IDX_THR, 32'hff, CSS_RESP_OKAY);
        wr(CSS_IDX_IFSEL, 32'hff, 4'hf, CSS_RESP_OKAY);
        rdchk(CSS_IDX_IFSEL, 32'h08, CSS_RESP_OKAY);
        wr(CSS_IDX_MUX, 32'hff, 4'hf, CSS_RESP_OKAY);
        rdchk(CSS_IDX_MUX, 32'h16, CSS_RESP_OKAY);
        $display("test registers done");
        // Threshold at max keeps the separator quiet during the mux sweep
        for (int i = 0; i < 24; i++) begin
            ifs = $random(seed);
            mx = $random(seed);
            ra = $random(seed);
            rg = $random(seed);
            wr(CSS_IDX_IFSEL, ifs, 4'hf, CSS_RESP_OKAY);
            wr(CSS_IDX_MUX, mx, 4'hf, CSS_RESP_OKAY);
            ana_set <= ra[3:0];
            dig_set <= rg[2:0];
            repeat (5) @(posedge aclk);
            chk({29'h0, sync_out}, {29'h0, exp_sync(ifs[3], mx[7:0],
                ana_set, dig_set)}, "mux");
        end
        $display("test mux sweep done");
        wr(CSS_IDX_POL, 32'h1, 4'hf, CSS_RESP_OKAY);
        wr(CSS_IDX_MUX, 32'h0, 4'hf, CSS_RESP_OKAY);
        ana_set <= 4'h8;
        repeat (6200) @(posedge aclk);
        rdchk(CSS_IDX_STAT, 32'hff, CSS_RESP_OKAY);
        ana_set <= 4'h0;
        repeat (60) @(posedge aclk);
        rd(CSS_IDX_STAT, d, r);
        chk({31'h0, d[7:0] < 8'hff}, 32'h1, "count down");
        repeat (5300) @(posedge aclk);
        rdchk(CSS_IDX_STAT, 32'h0, CSS_RESP_OKAY);
        ana_set <= 4'h8;
        repeat (400) @(posedge aclk);
        rd(CSS_IDX_STAT, d, r);
        chk({31'h0, d[7:0] >= 8'd19 && d[7:0] <= 8'd21}, 32'h1,
            "tick rate");
        ana_set <= 4'h0;
        repeat (600) @(posedge aclk);
        $display("test counter range done");
        sep_case(1'b1, 1'b0);
        sep_case(1'b0, 1'b1);
        end_sim();
    end
endmodule
